/* File: common/ptm_pkg.sv */
// package for the periodic timer: register map, field layout, modes, timing
package ptm_pkg;
	localparam int          PTM_CW           = 10;
	localparam int          PTM_AW           = 3;
	// register indices
	localparam logic [2:0]  PTM_REG_CTRL0    = 3'h0;
	localparam logic [2:0]  PTM_REG_CTRL1    = 3'h1;
	localparam logic [2:0]  PTM_REG_CNT_LO   = 3'h2;
	localparam logic [2:0]  PTM_REG_CNT_HI   = 3'h3;
	localparam logic [2:0]  PTM_REG_DUTY_LO  = 3'h4;
	localparam logic [2:0]  PTM_REG_DUTY_HI  = 3'h5;
	localparam logic [2:0]  PTM_REG_PER_LO   = 3'h6;
	localparam logic [2:0]  PTM_REG_PER_HI   = 3'h7;
	// control register zero fields
	localparam int          PTM_F_CKSEL      = 4;
	localparam int          PTM_F_ENABLE     = 3;
	// control register one fields
	localparam int          PTM_F_MODE       = 6;
	localparam int          PTM_F_PINFN      = 4;
	localparam int          PTM_F_OC         = 3;
	localparam int          PTM_F_POL        = 2;
	localparam int          PTM_F_CAPSRC     = 1;
	localparam int          PTM_F_CCLR       = 0;
	// status register bits, read at the control-zero index
	localparam int          PTM_F_AFLAG      = 1;
	localparam int          PTM_F_PFLAG      = 0;
	localparam logic [7:0]  PTM_RST_BYTE     = 8'h00;
	localparam logic [9:0]  PTM_CNT_MAX      = 10'h3FF;
	localparam logic [1:0]  PTM_DIV4_LAST    = 2'h3;
	localparam logic [5:0]  PTM_DIV16_LAST   = 6'h0F;
	localparam logic [5:0]  PTM_DIV64_LAST   = 6'h3F;
	localparam logic [5:0]  PTM_SUB_LAST     = 6'h3F;

	typedef enum logic [1:0] {
		PTM_MODE_CMP  = 2'h0,
		PTM_MODE_CAP  = 2'h1,
		PTM_MODE_PWM  = 2'h2,
		PTM_MODE_TMR  = 2'h3
	} ptm_mode_t;

	typedef enum logic [1:0] {
		PTM_PIN_KEEP  = 2'h0,
		PTM_PIN_LOW   = 2'h1,
		PTM_PIN_HIGH  = 2'h2,
		PTM_PIN_TOG   = 2'h3
	} ptm_pinfn_t;

	typedef enum logic [2:0] {
		PTM_CK_SYS4   = 3'h0,
		PTM_CK_SYS    = 3'h1,
		PTM_CK_H16    = 3'h2,
		PTM_CK_H64    = 3'h3,
		PTM_CK_SUB0   = 3'h4,
		PTM_CK_SUB1   = 3'h5,
		PTM_CK_EXTR   = 3'h6,
		PTM_CK_EXTF   = 3'h7
	} ptm_cksel_t;

	typedef struct packed {
		ptm_mode_t   mode;
		ptm_pinfn_t  pinfn;
		logic        oc;
		logic        pol;
		logic        capsrc;
		logic        cclr;
	} ptm_ctrl1_t;

	typedef struct packed {
		logic [2:0]  addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ptm_bus_t;
endpackage

/* File: rtl/ptm_timer.sv */
// periodic timer with duty and period comparators, compare-match, timer and PWM modes
`timescale 1ns/1ps
module ptm_timer (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        ext_clk_i,
	input  wire logic        sub_tick_i,
	output logic      [7:0]  rdata_o,
	output logic             pin_o,
	output logic             pin_oe_n_o,
	output logic             flag_a_o,
	output logic             flag_p_o
);
	// ==========================================================
	// bus and registers
	ptm_pkg::ptm_bus_t   bus;
	ptm_pkg::ptm_ctrl1_t ctrl1_r;
	logic [2:0]          cksel_r;
	logic                en_r;
	logic [9:0]          duty_r;
	logic [9:0]          per_r;
	logic [9:0]          cnt_r;
	logic                flag_a_r;
	logic                flag_p_r;
	logic                pin_r;
	logic                en_d_r;

	assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	function automatic logic hit_w(input ptm_pkg::ptm_bus_t b, input logic [2:0] idx);
		hit_w = b.wr && (b.addr == idx);
	endfunction

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl1_r <= ptm_pkg::ptm_ctrl1_t'(ptm_pkg::PTM_RST_BYTE);
			cksel_r <= 3'h0;
			en_r    <= 1'b0;
		end else begin
			if (hit_w(bus, ptm_pkg::PTM_REG_CTRL0)) begin
				cksel_r <= bus.wdata[ptm_pkg::PTM_F_CKSEL +: 3];
				en_r    <= bus.wdata[ptm_pkg::PTM_F_ENABLE];
			end
			if (hit_w(bus, ptm_pkg::PTM_REG_CTRL1))
				ctrl1_r <= ptm_pkg::ptm_ctrl1_t'(bus.wdata);
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			duty_r <= 10'h000;
			per_r  <= 10'h000;
		end else begin
			if (hit_w(bus, ptm_pkg::PTM_REG_DUTY_LO))
				duty_r[7:0] <= bus.wdata;
			if (hit_w(bus, ptm_pkg::PTM_REG_DUTY_HI))
				duty_r[9:8] <= bus.wdata[1:0];
			if (hit_w(bus, ptm_pkg::PTM_REG_PER_LO))
				per_r[7:0] <= bus.wdata;
			if (hit_w(bus, ptm_pkg::PTM_REG_PER_HI))
				per_r[9:8] <= bus.wdata[1:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= 8'h00;
			if (bus.rd) begin
				case (bus.addr)
					ptm_pkg::PTM_REG_CTRL0:   rdata_o <= {1'b0, cksel_r, en_r, 1'b0, flag_a_r, flag_p_r};
					ptm_pkg::PTM_REG_CTRL1:   rdata_o <= ctrl1_r;
					ptm_pkg::PTM_REG_CNT_LO:  rdata_o <= cnt_r[7:0];
					ptm_pkg::PTM_REG_CNT_HI:  rdata_o <= {6'h00, cnt_r[9:8]};
					ptm_pkg::PTM_REG_DUTY_LO: rdata_o <= duty_r[7:0];
					ptm_pkg::PTM_REG_DUTY_HI: rdata_o <= {6'h00, duty_r[9:8]};
					ptm_pkg::PTM_REG_PER_LO:  rdata_o <= per_r[7:0];
					ptm_pkg::PTM_REG_PER_HI:  rdata_o <= {6'h00, per_r[9:8]};
					default:                  rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// counter clock selection
	logic       ext_s1_r;
	logic       ext_s2_r;
	logic       ext_s3_r;
	logic       ext_lvl_r;
	logic [5:0] pre_r;
	logic       tick;
	logic       ext_rise;
	logic       ext_fall;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ext_s1_r  <= 1'b0;
			ext_s2_r  <= 1'b0;
			ext_s3_r  <= 1'b0;
			ext_lvl_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk_i;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			if (ext_s2_r == ext_s3_r)
				ext_lvl_r <= ext_s3_r;
		end
	end

	assign ext_rise = (ext_s2_r == ext_s3_r) && ext_s3_r && !ext_lvl_r;
	assign ext_fall = (ext_s2_r == ext_s3_r) && !ext_s3_r && ext_lvl_r;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			pre_r <= 6'h00;
		else
			pre_r <= pre_r + 6'h01;
	end

	always_comb begin
		case (ptm_pkg::ptm_cksel_t'(cksel_r))
			ptm_pkg::PTM_CK_SYS4: tick = (pre_r[1:0] == ptm_pkg::PTM_DIV4_LAST);
			ptm_pkg::PTM_CK_SYS:  tick = 1'b1;
			ptm_pkg::PTM_CK_H16:  tick = ({2'h0, pre_r[3:0]} == ptm_pkg::PTM_DIV16_LAST);
			ptm_pkg::PTM_CK_H64:  tick = (pre_r == ptm_pkg::PTM_DIV64_LAST);
			ptm_pkg::PTM_CK_SUB0: tick = sub_tick_i;
			ptm_pkg::PTM_CK_SUB1: tick = sub_tick_i;
			ptm_pkg::PTM_CK_EXTR: tick = ext_rise;
			ptm_pkg::PTM_CK_EXTF: tick = ext_fall;
			default:              tick = 1'b0;
		endcase
	end

	// ==========================================================
	// counter and comparators
	logic is_pwm;
	logic match_a;
	logic match_p;
	logic wrap;
	logic clr_cnt;
	logic ev_a;
	logic ev_p;
	logic en_rise;

	assign en_rise = en_r && !en_d_r;
	assign is_pwm  = (ctrl1_r.mode == ptm_pkg::PTM_MODE_PWM);
	// compare on the next counter value so a period of n gives n ticks
	assign match_a = (duty_r != 10'h000) && (cnt_r + 10'h001 == duty_r);
	assign match_p = (per_r != 10'h000) && (cnt_r + 10'h001 == per_r);
	assign wrap    = (cnt_r == ptm_pkg::PTM_CNT_MAX);

	always_comb begin
		if (is_pwm || !ctrl1_r.cclr)
			clr_cnt = match_p || ((per_r == 10'h000) && wrap);
		else
			clr_cnt = match_a || wrap;
	end

	assign ev_a = en_r && tick && match_a && ctrl1_r.mode != ptm_pkg::PTM_MODE_CAP;
	assign ev_p = en_r && tick && match_p && ctrl1_r.mode != ptm_pkg::PTM_MODE_CAP
		&& (is_pwm || !ctrl1_r.cclr);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r  <= 10'h000;
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= en_r;
			if (en_rise)
				cnt_r <= 10'h000;
			else if (en_r && tick) begin
				if (clr_cnt)
					cnt_r <= 10'h000;
				else
					cnt_r <= cnt_r + 10'h001;
			end
		end
	end

	// ==========================================================
	// request flags, sticky; writing one to a status bit clears it
	logic clr_a;
	logic clr_p;

	assign clr_a = hit_w(bus, ptm_pkg::PTM_REG_CTRL0) && bus.wdata[ptm_pkg::PTM_F_AFLAG];
	assign clr_p = hit_w(bus, ptm_pkg::PTM_REG_CTRL0) && bus.wdata[ptm_pkg::PTM_F_PFLAG];

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			flag_a_r <= 1'b0;
			flag_p_r <= 1'b0;
		end else begin
			flag_a_r <= ev_a || (flag_a_r && !clr_a);
			flag_p_r <= ev_p || (flag_p_r && !clr_p);
		end
	end

	// ==========================================================
	// output pin
	logic pwm_on;
	logic pwm_act;
	logic pwm_lvl;

	// pwm_on tracks active phase: set at period start, cleared at duty match
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			pwm_on <= 1'b0;
		else if (en_rise)
			pwm_on <= 1'b1;
		else if (en_r && tick) begin
			if (clr_cnt)
				pwm_on <= 1'b1;
			else if (match_a && (duty_r < per_r || per_r == 10'h000))
				pwm_on <= 1'b0;
		end
	end

	always_comb begin
		case (ctrl1_r.pinfn)
			ptm_pkg::PTM_PIN_KEEP: pwm_act = 1'b0;
			ptm_pkg::PTM_PIN_LOW:  pwm_act = 1'b1;
			ptm_pkg::PTM_PIN_HIGH: pwm_act = pwm_on;
			default:               pwm_act = 1'b0;
		endcase
		pwm_lvl = (pwm_act ~^ ctrl1_r.oc) ^ ctrl1_r.pol;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			pin_r <= 1'b0;
		else if (ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP) begin
			if (en_rise)
				pin_r <= ctrl1_r.oc;
			else if (ev_a) begin
				case (ctrl1_r.pinfn)
					ptm_pkg::PTM_PIN_LOW:  pin_r <= 1'b0;
					ptm_pkg::PTM_PIN_HIGH: pin_r <= 1'b1;
					ptm_pkg::PTM_PIN_TOG:  pin_r <= !pin_r;
					default:               pin_r <= pin_r;
				endcase
			end
		end else if (is_pwm)
			pin_r <= pwm_lvl;
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pin_o      <= 1'b0;
			pin_oe_n_o <= 1'b1;
			flag_a_o   <= 1'b0;
			flag_p_o   <= 1'b0;
		end else begin
			pin_o      <= (ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP) ? (pin_r ^ ctrl1_r.pol) : pin_r;
			pin_oe_n_o <= !(ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP || is_pwm);
			flag_a_o   <= flag_a_r;
			flag_p_o   <= flag_p_r;
		end
	end

	// ==========================================================
	// checks
	a_p_flag_gated: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.cclr && !is_pwm && !flag_p_r) |=> !flag_p_r) else $error("p flag raised with clear-select high");

	a_zero_duty_noa: assert property (@(posedge clock_i) disable iff (rst_i)
		(duty_r == 10'h000) |-> !ev_a) else $error("a flag raised with zero duty");

	a_enable_zeroes: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(en_r) |=> (cnt_r == 10'h000)) else $error("counter not zeroed on enable");

	a_hold_stopped: assert property (@(posedge clock_i) disable iff (rst_i)
		(!en_r && !en_d_r) |=> $stable(cnt_r)) else $error("counter moved while stopped");

	a_flag_sticky: assert property (@(posedge clock_i) disable iff (rst_i)
		(flag_a_r && !clr_a) |=> flag_a_r) else $error("a flag dropped without clear");

	a_flag_set: assert property (@(posedge clock_i) disable iff (rst_i)
		ev_p |=> ##1 flag_p_o) else $error("p flag not shown");

	a_timer_nopin: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.mode == ptm_pkg::PTM_MODE_TMR) |=> pin_oe_n_o) else $error("pin driven in timer mode");

	a_init_level: assert property (@(posedge clock_i) disable iff (rst_i)
		(en_rise && ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP && $stable(ctrl1_r)) |=> (pin_r == ctrl1_r.oc))
		else $error("pin not at initial level");

	a_overflow_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
		(en_r && !en_rise && tick && wrap && per_r == 10'h000 && !ctrl1_r.cclr) |=> (cnt_r == 10'h000))
		else $error("no overflow wrap");

	a_cmp_drives: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP) |=> !pin_oe_n_o) else $error("pin released in compare mode");

	a_pwm_drives: assert property (@(posedge clock_i) disable iff (rst_i)
		is_pwm |=> !pin_oe_n_o) else $error("pin released in pwm mode");

	a_pin_holds: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP && !en_rise && !ev_a) |=> $stable(pin_r))
		else $error("pin changed without a match");

	a_pin_toggles: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP && !en_rise && ev_a && ctrl1_r.pinfn == ptm_pkg::PTM_PIN_TOG)
		|=> (pin_r != $past(pin_r))) else $error("pin did not toggle");

	a_pin_goes_high: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP && !en_rise && ev_a && ctrl1_r.pinfn == ptm_pkg::PTM_PIN_HIGH)
		|=> pin_r) else $error("pin did not go high");

	a_pin_goes_low: assert property (@(posedge clock_i) disable iff (rst_i)
		(ctrl1_r.mode == ptm_pkg::PTM_MODE_CMP && !en_rise && ev_a && ctrl1_r.pinfn == ptm_pkg::PTM_PIN_LOW)
		|=> !pin_r) else $error("pin did not go low");

	a_period_clear: assert property (@(posedge clock_i) disable iff (rst_i)
		(en_r && !en_rise && tick && match_p && (is_pwm || !ctrl1_r.cclr)) |=> (cnt_r == 10'h000))
		else $error("counter not cleared on period match");

	a_duty_clear: assert property (@(posedge clock_i) disable iff (rst_i)
		(en_r && !en_rise && tick && match_a && ctrl1_r.cclr && !is_pwm) |=> (cnt_r == 10'h000))
		else $error("counter not cleared on duty match");

	a_count_step: assert property (@(posedge clock_i) disable iff (rst_i)
		(en_r && !en_rise && tick && !clr_cnt) |=> (cnt_r == $past(cnt_r) + 10'h001))
		else $error("counter did not advance by one");

	a_flag_clears: assert property (@(posedge clock_i) disable iff (rst_i)
		(clr_a && !ev_a) |=> !flag_a_r) else $error("a flag not cleared");

	a_set_wins: assert property (@(posedge clock_i) disable iff (rst_i)
		(ev_p && clr_p) |=> flag_p_r) else $error("clear beat a new p event");

	a_a_flag_set: assert property (@(posedge clock_i) disable iff (rst_i)
		ev_a |=> flag_a_r) else $error("a flag not raised on match");

	a_per_high_zero: assert property (@(posedge clock_i) disable iff (rst_i)
		(rd_i && addr_i == ptm_pkg::PTM_REG_PER_HI) |=> (rdata_o[7:2] == 6'h00))
		else $error("period high upper bits set");

	a_pwm_inactive: assert property (@(posedge clock_i) disable iff (rst_i)
		(is_pwm && ctrl1_r.pinfn == ptm_pkg::PTM_PIN_KEEP) |=> (pin_r == ($past(ctrl1_r.pol) ^ !$past(ctrl1_r.oc))))
		else $error("forced inactive level wrong");

	a_pwm_active: assert property (@(posedge clock_i) disable iff (rst_i)
		(is_pwm && ctrl1_r.pinfn == ptm_pkg::PTM_PIN_LOW) |=> (pin_r == ($past(ctrl1_r.pol) ^ $past(ctrl1_r.oc))))
		else $error("forced active level wrong");
endmodule

/* File: testbench/ptm_pin_load.sv */
// load model on the timer output pin: level, high-cycle and edge counts
`timescale 1ns/1ps
module ptm_pin_load (
	input  wire logic         clock_i,
	input  wire logic         rst_i,
	input  wire logic         pin_i,
	input  wire logic         oe_n_i,
	input  wire logic         clr_i,
	output logic              level_o,
	output logic      [15:0]  highs_o,
	output logic      [15:0]  edges_o
);
	logic                     last_r;

	// released pin falls to the pull-down level
	assign level_o = (oe_n_i === 1'b0) ? pin_i : 1'b0;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			highs_o <= 16'h0000;
			edges_o <= 16'h0000;
		end else if (clr_i) begin
			highs_o <= 16'h0000;
			edges_o <= 16'h0000;
		end else begin
			highs_o <= highs_o + {15'h0000, level_o};
			edges_o <= edges_o + {15'h0000, level_o !== last_r};
		end
	end

	always_ff @(posedge clock_i) begin
		last_r <= level_o;
	end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the periodic timer
`timescale 1ns/1ps
module tb;
	logic              clock_i = 1'b0;
	logic              rst_i   = 1'b1;
	logic       [2:0]  addr_i  = 3'h0;
	logic       [7:0]  wdata_i = 8'h00;
	logic              wr_i    = 1'b0;
	logic              rd_i    = 1'b0;
	logic              clr     = 1'b0;
	logic              ext     = 1'b0;
	logic              sub     = 1'b0;
	logic       [7:0]  rdata_o;
	logic              pin_o, pin_oe_n_o, flag_a_o, flag_p_o, level;
	logic      [15:0]  highs, edges;
	logic       [7:0]  d, e;
	int                num_errors  = 0;
	int                comparisons = 0;

	always #12.5 clock_i = ~clock_i;

	ptm_timer DUT (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .ext_clk_i(ext), .sub_tick_i(sub), .rdata_o(rdata_o), .pin_o(pin_o),
		.pin_oe_n_o(pin_oe_n_o), .flag_a_o(flag_a_o), .flag_p_o(flag_p_o));
	ptm_pin_load LOAD (.clock_i(clock_i), .rst_i(rst_i), .pin_i(pin_o), .oe_n_i(pin_oe_n_o),
		.clr_i(clr), .level_o(level), .highs_o(highs), .edges_o(edges));

	// =====================================
	// shared tasks
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clock_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clock_i);
		wr_i    <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clock_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clock_i);
		rd_i   <= 1'b0;
		#1 v = rdata_o;
	endtask

	// stop, clear flags, load values, then start the counter on the system clock
	task automatic cfg(input logic [7:0] c1, input logic [9:0] per, input logic [9:0] duty);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h13);
		wr(ptm_pkg::PTM_REG_CTRL1, c1);
		wr(ptm_pkg::PTM_REG_DUTY_LO, duty[7:0]);
		wr(ptm_pkg::PTM_REG_DUTY_HI, {6'h00, duty[9:8]});
		wr(ptm_pkg::PTM_REG_PER_LO, per[7:0]);
		wr(ptm_pkg::PTM_REG_PER_HI, {6'h00, per[9:8]});
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h18);
	endtask

	task automatic meas(input int n);
		@(posedge clock_i);
		clr <= 1'b1;
		@(posedge clock_i);
		clr <= 1'b0;
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// =====================================
	// scenarios
	task automatic t_regs();
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0], d);
			check("reset value", {8'h00, d}, 16'h0000);
		end
		wr(ptm_pkg::PTM_REG_PER_HI, 8'hFF);
		wr(ptm_pkg::PTM_REG_PER_LO, 8'hFF);
		rd(ptm_pkg::PTM_REG_PER_HI, d);
		check("period high", {8'h00, d}, 16'h0003);
		rd(ptm_pkg::PTM_REG_PER_LO, d);
		check("period low", {8'h00, d}, 16'h00FF);
	endtask

	task automatic pwm(input logic [7:0] c1, input logic [9:0] per, input logic [9:0] duty,
		input int n, input logic [15:0] exp);
		cfg(c1, per, duty);
		repeat (n + 20) @(posedge clock_i);
		meas(n);
		check("pwm high cycles", highs, exp);
		check("pwm pin driven", {15'h0000, pin_oe_n_o}, 16'h0000);
		rd(ptm_pkg::PTM_REG_CNT_LO, d);
		rd(ptm_pkg::PTM_REG_CNT_LO, e);
		check("pwm counter runs", {15'h0000, d != e}, 16'h0001);
	endtask

	task automatic cmp(input logic [7:0] c1, input logic [9:0] per, input logic [9:0] duty,
		input int n, input logic [15:0] exp_edges, input logic [1:0] exp_fl, input logic [1:0] mask,
		input logic exp_oe_n);
		cfg(c1, per, duty);
		repeat (30) @(posedge clock_i);
		meas(n);
		check("pin edges", edges, exp_edges);
		check("pin enable", {15'h0000, pin_oe_n_o}, {15'h0000, exp_oe_n});
		rd(ptm_pkg::PTM_REG_CTRL0, d);
		check("status flags", {14'h0000, d[1:0] & mask}, {14'h0000, exp_fl});
		check("flag outputs", {14'h0000, {flag_a_o, flag_p_o} & mask}, {14'h0000, exp_fl});
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h10);
		rd(ptm_pkg::PTM_REG_CTRL0, d);
		check("flags held", {14'h0000, d[1:0] & mask}, {14'h0000, exp_fl});
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h13);
		rd(ptm_pkg::PTM_REG_CTRL0, d);
		check("flags cleared", {14'h0000, d[1:0]}, 16'h0000);
	endtask

	task automatic t_enable();
		cfg(8'h08, 10'd10, 10'd4);
		repeat (3) @(posedge clock_i);
		#1;
		check("initial level high", {15'h0000, level}, 16'h0001);
		repeat (20) @(posedge clock_i);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h10);
		rd(ptm_pkg::PTM_REG_CNT_LO, d);
		repeat (5) @(posedge clock_i);
		rd(ptm_pkg::PTM_REG_CNT_LO, e);
		check("counter held", {8'h00, e}, {8'h00, d});
		cfg(8'h00, 10'd10, 10'd4);
		rd(ptm_pkg::PTM_REG_CNT_LO, d);
		check("counter restarts", {15'h0000, d < 8'h05}, 16'h0001);
		check("initial level low", {15'h0000, level}, 16'h0000);
	endtask

	// divide-by-four, sub tick and external rising edge as counter clocks
	task automatic t_clksel();
		cfg(8'hC0, 10'd0, 10'd0);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h03);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h08);
		repeat (40) @(posedge clock_i);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h00);
		rd(ptm_pkg::PTM_REG_CNT_LO, d);
		check("divide by four", {15'h0000, (d == 8'h0A) || (d == 8'h0B)}, 16'h0001);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h48);
		repeat (3) begin
			repeat (4) @(posedge clock_i);
			sub <= 1'b1;
			@(posedge clock_i);
			sub <= 1'b0;
		end
		repeat (2) @(posedge clock_i);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h40);
		rd(ptm_pkg::PTM_REG_CNT_LO, d);
		check("sub clock ticks", {8'h00, d}, 16'h0003);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h68);
		repeat (5) begin
			repeat (4) @(posedge clock_i);
			ext <= 1'b1;
			repeat (4) @(posedge clock_i);
			ext <= 1'b0;
		end
		repeat (6) @(posedge clock_i);
		wr(ptm_pkg::PTM_REG_CTRL0, 8'h60);
		rd(ptm_pkg::PTM_REG_CNT_LO, d);
		check("external rising ticks", {8'h00, d}, 16'h0005);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#(25.0 * 30000);
		num_errors++;
		end_sim();
	end

	initial begin
		repeat (16) @(posedge clock_i);
		rst_i <= 1'b0;
		t_regs();
		pwm(8'hA8, 10'd8, 10'd3, 80, 16'd30);
		pwm(8'hAC, 10'd8, 10'd3, 80, 16'd50);
		pwm(8'hA0, 10'd8, 10'd3, 80, 16'd50);
		pwm(8'hA8, 10'd0, 10'd512, 1024, 16'd512);
		pwm(8'hA9, 10'd8, 10'd8, 80, 16'd80);
		pwm(8'hA8, 10'd8, 10'd9, 80, 16'd80);
		pwm(8'h88, 10'd8, 10'd3, 80, 16'd0);
		pwm(8'h98, 10'd8, 10'd3, 80, 16'd80);
		cmp(8'h30, 10'd10, 10'd4, 100, 16'd10, 2'b11, 2'b11, 1'b0);
		cmp(8'h31, 10'd3, 10'd6, 60, 16'd10, 2'b10, 2'b11, 1'b0);
		cmp(8'hF0, 10'd10, 10'd4, 100, 16'd0, 2'b11, 2'b11, 1'b1);
		cmp(8'hC0, 10'd0, 10'd0, 1100, 16'd0, 2'b00, 2'b10, 1'b1);
		t_enable();
		t_clksel();
		end_sim();
	end
endmodule
